// file: src/scs_top.sv
// synchronism-check stages and system-split detector
`include "scs_defines.svh"
`default_nettype none
module scs_top #(
    parameter logic [`SCS_TICK_W-1:0] TICK_CYCLES = `SCS_TICK_10MS  // cycles per 10 ms
) (
    input wire logic clock,                     // 10 MHz
    input wire logic rst_n,                     // async, active low
    input wire logic meas_update,               // new measurement pulse
    input wire logic line_live,                 // line live flag
    input wire logic bus_live,                  // bus live flag
    input wire scs_pkg::scs_ang_t phase_angle,  // angle magnitude, degrees
    input wire logic angle_decreasing,          // magnitude falling
    input wire scs_pkg::scs_slip_t slip_freq,   // mHz
    input wire scs_pkg::scs_volt_t line_volts,  // line magnitude
    input wire scs_pkg::scs_volt_t bus_volts,   // bus magnitude
    input wire logic checks_enable,             // global enable setting
    input wire logic s1_status,                 // stage one status setting
    input wire logic s1_user_en,                // stage one user scheme enable
    input wire scs_pkg::scs_ang_t s1_angle,     // stage one angle
    input wire scs_pkg::scs_slip_e s1_slip_mode,// stage one slip control
    input wire scs_pkg::scs_slip_t s1_slip,     // stage one slip setting
    input wire scs_pkg::scs_time_t s1_timer,    // stage one timer
    input wire logic s2_status,                 // stage two status setting
    input wire logic s2_user_en,                // stage two user scheme enable
    input wire scs_pkg::scs_ang_t s2_angle,     // stage two angle
    input wire scs_pkg::scs_slip_e s2_slip_mode,// stage two slip control
    input wire logic s2_comp,                   // freq plus compensation mode
    input wire scs_pkg::scs_slip_t s2_slip,     // stage two slip setting
    input wire scs_pkg::scs_time_t s2_timer,    // stage two timer
    input wire scs_pkg::scs_time_t cb_close_time, // breaker close time
    input wire scs_pkg::scs_vblk_t vblock_sel,  // voltage block selection
    input wire scs_pkg::scs_volt_t uv_set,      // undervoltage setting
    input wire scs_pkg::scs_volt_t ov_set,      // overvoltage setting
    input wire scs_pkg::scs_volt_t diff_set,    // difference setting
    input wire logic ss_status,                 // split status setting
    input wire logic ss_user_en,                // split user scheme enable
    input wire scs_pkg::scs_ang_t ss_angle,     // split angle
    input wire logic ss_uv_block,               // split undervoltage block
    input wire scs_pkg::scs_volt_t ss_uv_set,   // split undervoltage
    input wire scs_pkg::scs_time_t ss_timer,    // split minimum hold
    output logic sync_stage_one,                // stage one ok
    output logic sync_stage_two,                // stage two ok
    output logic sync_either,                   // either stage ok
    output logic system_split                   // split detected
);
    import scs_pkg::*;
    typedef struct packed {
        logic [`SCS_TICK_W-1:0] div;
        logic tick;
        logic upd;
        logic live_ok;
        logic ss_cond;
        scs_time_t ss_left;
        logic split;
        logic s1;
        logic s2;
        logic either;
    } scs_top_s;
    scs_top_s q, d;
    logic ok1, ok2, under_voltage_block, over_voltage_block, voltage_difference_block, ss_base;
    scs_volt_t vdiff;
    scs_stage_if if1 ();
    scs_stage_if if2 ();

    function automatic logic both_above(input scs_volt_t a, input scs_volt_t b, input scs_volt_t lim);
        both_above = (a > lim) && (b > lim);
    endfunction : both_above

    assign if1.en = checks_enable && s1_status && s1_user_en; // RULE_01
    assign if1.ang_set = s1_angle;
    assign if1.slip_mode = s1_slip_mode;
    assign if1.comp_mode = 1'b0;
    assign if1.slip_set = s1_slip;
    assign if1.slip_time = s1_timer;
    assign if1.need_decr = 1'b0; // RULE_04
    assign if1.half_angle = 1'b0;
    assign if2.en = checks_enable && s2_status && s2_user_en; // RULE_01
    assign if2.ang_set = s2_angle;
    assign if2.slip_mode = s2_slip_mode;
    assign if2.comp_mode = s2_comp; // RULE_13
    assign if2.slip_set = s2_slip;
    assign if2.slip_time = s2_timer;
    assign if2.need_decr = 1'b1; // RULE_04 RULE_11
    assign if2.half_angle = 1'b1; // RULE_10
    assign ok1 = if1.ok;
    assign ok2 = if2.ok;

    // RULE_18
    scs_stage u_stage1 (
        .clock(clock),
        .rst_n(rst_n),
        .upd(q.upd),
        .tick(q.tick),
        .live_ok(q.live_ok),
        .angle(phase_angle),
        .decreasing(angle_decreasing),
        .slip(slip_freq),
        .cb_close(cb_close_time),
        .cfg(if1)
    );
    scs_stage u_stage2 (
        .clock(clock),
        .rst_n(rst_n),
        .upd(q.upd),
        .tick(q.tick),
        .live_ok(q.live_ok),
        .angle(phase_angle),
        .decreasing(angle_decreasing),
        .slip(slip_freq),
        .cb_close(cb_close_time),
        .cfg(if2)
    );

    always_comb
    begin
        vdiff = (line_volts > bus_volts) ? (line_volts - bus_volts) : (bus_volts - line_volts);
        under_voltage_block = !vblock_sel[0] || both_above(line_volts, bus_volts, uv_set); // RULE_07
        over_voltage_block = !vblock_sel[1] || ((line_volts < ov_set) && (bus_volts < ov_set)); // RULE_06
        voltage_difference_block = !vblock_sel[2] || (vdiff < diff_set); // RULE_08
        ss_base = checks_enable && ss_status && ss_user_en // RULE_14
            && line_live && bus_live && (phase_angle > ss_angle) // RULE_15
            && (!ss_uv_block || both_above(line_volts, bus_volts, ss_uv_set)); // RULE_16
        d = q;
        d.tick = 1'b0;
        if (q.div >= TICK_CYCLES - `SCS_TICK_W'(1))
        begin
            d.div = `SCS_NO_TICK;
            d.tick = 1'b1;
        end
        else
        begin
            d.div = q.div + `SCS_TICK_W'(1);
        end
        d.upd = meas_update;
        if (meas_update)
        begin
            d.live_ok = line_live && bus_live && under_voltage_block // RULE_02 RULE_19
                && over_voltage_block && voltage_difference_block;
            d.ss_cond = ss_base;
        end
        if (q.ss_cond)
        begin
            d.ss_left = ss_timer; // RULE_17
        end
        else if (q.tick && q.ss_left != `SCS_TIME_ZERO)
        begin
            d.ss_left = q.ss_left - `SCS_ONE_TICK;
        end
        d.split = q.ss_cond || (q.split && d.ss_left != `SCS_TIME_ZERO); // RULE_17
        d.s1 = ok1;
        d.s2 = ok2;
        d.either = ok1 || ok2; // RULE_18
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign sync_stage_one = q.s1;
    assign sync_stage_two = q.s2;
    assign sync_either = q.either;
    assign system_split = q.split;

    split_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        q.ss_cond |=> system_split) else $error("split not set"); // RULE_15
    split_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        ($fell(q.ss_cond) && ss_timer != `SCS_TIME_ZERO && $stable(ss_timer)) |=> system_split)
        else $error("split dropped early"); // RULE_17
    either_or_a: assert property (@(posedge clock) disable iff (!rst_n)
        sync_either == ($past(ok1) || $past(ok2))) else $error("either mismatch"); // RULE_18
    live_need_a: assert property (@(posedge clock) disable iff (!rst_n)
        (meas_update && !(line_live && bus_live)) |=> !q.live_ok) else $error("live ignored"); // RULE_02
    stage_en_a: assert property (@(posedge clock) disable iff (!rst_n)
        (meas_update && !checks_enable) |-> ##3 (!sync_stage_one && !sync_stage_two))
        else $error("stage not disabled"); // RULE_01
    split_en_a: assert property (@(posedge clock) disable iff (!rst_n)
        (meas_update && !ss_user_en) |=> !q.ss_cond) else $error("split not gated"); // RULE_14
    tick_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
        q.tick |=> !q.tick) else $error("tick too fast"); // RULE_09
    ov_blk_a: assert property (@(posedge clock) disable iff (!rst_n)
        (meas_update && vblock_sel[1] && line_volts >= ov_set) |=> !q.live_ok)
        else $error("overvoltage ignored"); // RULE_06
endmodule : scs_top
`default_nettype wire

// file: src/scs_defines.svh
// constants for the synchronism-check and system-split block
// How it works
// RULE_01: a check stage acts only with global, stage and user enables all set.
// RULE_02: a check stage output needs line live and bus live.
// RULE_03: measured angle must be strictly below the stage angle setting.
// RULE_04: stage two also needs a decreasing angle; stage one accepts either.
// RULE_05: frequency slip modes need slip strictly below the slip setting.
// RULE_06: overvoltage blocking needs both voltages below the overvoltage setting.
// RULE_07: undervoltage blocking needs both voltages above the undervoltage setting.
// RULE_08: difference blocking needs the voltage difference below its setting.
// RULE_09: timer slip modes need all conditions held for the slip timer.
// RULE_10: timer sets effective slip limit: 2A/(T*360) stage one, A/(T*360) stage two.
// RULE_11: stage two blocks once the angle passes zero and starts increasing.
// RULE_12: frequency plus timer needs slip below both limits.
// RULE_13: compensation mode times close from slip and breaker close time.
// RULE_14: split detector acts only with global, split and user enables.
// RULE_15: split sets when both live and angle strictly exceeds split setting.
// RULE_16: split undervoltage blocking needs both voltages above its setting.
// RULE_17: split output holds while true and at least for the split timer.
// RULE_18: the two stages run independently with separate settings.
// RULE_19: every measurement update re-evaluates comparisons and timers.
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_TICK_10MS 17'd100000
`define SCS_TICK_W 17
`define SCS_ONE_TICK 14'h0001
`define SCS_TIME_ZERO 14'h0000
`define SCS_FULL_TURN 32'd360
`define SCS_NO_TICK 17'h00000
`endif

// file: src/scs_pkg.sv
// types for the synchronism-check and system-split block
`default_nettype none
package scs_pkg;
    typedef enum logic [1:0] {SCS_SLIP_NONE, SCS_SLIP_FREQ, SCS_SLIP_TIMER, SCS_SLIP_BOTH} scs_slip_e;
    // bit 0 uv, bit 1 ov, bit 2 diff
    typedef logic [2:0] scs_vblk_t;
    typedef logic [13:0] scs_time_t;  // 10 ms steps
    typedef logic [15:0] scs_volt_t;
    typedef logic [7:0] scs_ang_t;    // whole degrees
    typedef logic [15:0] scs_slip_t;  // mHz
endpackage : scs_pkg
`default_nettype wire

// file: src/scs_stage_if.sv
// settings and result of one synchronism-check stage
`default_nettype none
interface scs_stage_if;
    logic en;
    scs_pkg::scs_ang_t ang_set;
    scs_pkg::scs_slip_e slip_mode;
    logic comp_mode;
    scs_pkg::scs_slip_t slip_set;
    scs_pkg::scs_time_t slip_time;
    logic need_decr;
    logic half_angle;
    logic ok;
    modport top (output en, ang_set, slip_mode, comp_mode, slip_set, slip_time, need_decr, half_angle, input ok);
    modport stage (input en, ang_set, slip_mode, comp_mode, slip_set, slip_time, need_decr, half_angle, output ok);
endinterface : scs_stage_if
`default_nettype wire

// file: src/scs_stage.sv
// one synchronism-check stage
`include "scs_defines.svh"
`default_nettype none
module scs_stage (
    input wire logic clock,                    // 10 MHz
    input wire logic rst_n,                    // async, active low
    input wire logic upd,                      // measurement update pulse
    input wire logic tick,                     // 10 ms enable
    input wire logic live_ok,                  // both live and voltage blocks pass
    input wire scs_pkg::scs_ang_t angle,       // measured angle magnitude
    input wire logic decreasing,               // angle magnitude falling
    input wire scs_pkg::scs_slip_t slip,       // measured slip
    input wire scs_pkg::scs_time_t cb_close,   // breaker close time
    scs_stage_if.stage cfg                     // settings and result
);
    import scs_pkg::*;
    typedef struct packed {
        scs_time_t held;
        logic ok;
        logic cond;
    } scs_st_s;
    scs_st_s q, d;
    logic use_freq, use_timer, base, slip_lim;
    // 64 bits: slip times a long timer times 360 overflows 32 bits
    logic [63:0] lhs, rhs, adv;

    always_comb
    begin
        use_freq = (cfg.slip_mode == SCS_SLIP_FREQ) || (cfg.slip_mode == SCS_SLIP_BOTH); // RULE_05
        use_timer = (cfg.slip_mode == SCS_SLIP_TIMER) || (cfg.slip_mode == SCS_SLIP_BOTH); // RULE_09
        // slip(mHz)*T(10ms)*360 < k*A*100000; k=2 stage one, 1 stage two
        lhs = 64'(slip) * 64'(cfg.slip_time) * 64'(`SCS_FULL_TURN);
        rhs = 64'(cfg.ang_set) * 64'(`SCS_TICK_10MS) * (cfg.half_angle ? 64'h1 : 64'h2);
        slip_lim = !use_timer || (lhs < rhs); // RULE_10 RULE_12
        // angle advance during breaker closing: slip*360*t/100000 degrees
        adv = (64'(slip) * 64'(`SCS_FULL_TURN) * 64'(cb_close)) / 64'(`SCS_TICK_10MS);
        base = cfg.en && live_ok // RULE_01 RULE_02
            && (cfg.comp_mode ? (64'(angle) <= 64'(cfg.ang_set) + adv) // RULE_13
                              : (angle < cfg.ang_set)) // RULE_03
            && (!cfg.need_decr || decreasing) // RULE_04 RULE_11
            && (!(use_freq || cfg.comp_mode) || (slip < cfg.slip_set)) // RULE_05
            && slip_lim;
        d = q;
        if (upd)
        begin
            d.cond = base; // RULE_19
        end
        if (!d.cond)
        begin
            d.held = `SCS_TIME_ZERO;
        end
        else if (tick && q.cond && q.held != '1)
        begin
            d.held = q.held + `SCS_ONE_TICK;
        end
        d.ok = d.cond && (!use_timer || d.held >= cfg.slip_time); // RULE_09
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
    assign cfg.ok = q.ok;

    timer_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        (q.ok && use_timer) |-> (q.held >= cfg.slip_time)) else $error("timer bypassed"); // RULE_09
    cond_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        q.ok |-> q.cond) else $error("output without condition"); // RULE_18
endmodule : scs_stage
`default_nettype wire

// file: testbench/scs_psl_model.sv
// user scheme logic and breaker close model facing the check block
`default_nettype none
module scs_psl_model (
    input wire logic clock,        // 10 MHz
    input wire logic rst_n,        // async, active low
    input wire logic req_s1,       // bench asks for stage one
    input wire logic req_s2,       // bench asks for stage two
    input wire logic req_ss,       // bench asks for split detector
    input wire logic sync_either,  // either stage ok
    output logic s1_user_en,       // stage one user enable
    output logic s2_user_en,       // stage two user enable
    output logic ss_user_en,       // split user enable
    output logic close_cmd         // breaker close request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic close_q;
    // enables pass straight through so they meet the very next update
    assign s1_user_en = req_s1;
    assign s2_user_en = req_s2;
    assign ss_user_en = req_ss;
    assign close_cmd = close_q;
    // either stage may allow closure, a cycle late like real scheme logic
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            close_q <= 1'b0;
        else
            close_q <= sync_either;
    end
endmodule : scs_psl_model
`default_nettype wire

// file: testbench/scs_top_tb_top.sv
// self-checking bench for the synchronism-check and system-split block
`default_nettype none
module scs_top_tb_top;
    import scs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, meas_update, line_live, bus_live, angle_decreasing, checks_enable, s1_status, s2_status;
    logic s1_user_en, s2_user_en, ss_user_en, s2_comp, ss_status, ss_uv_block, req_s1, req_s2, req_ss;
    logic sync_stage_one, sync_stage_two, sync_either, system_split, close_cmd;
    scs_ang_t phase_angle, s1_angle, s2_angle, ss_angle;
    scs_slip_e s1_slip_mode, s2_slip_mode;
    scs_slip_t slip_freq, s1_slip, s2_slip;
    scs_time_t s1_timer, s2_timer, cb_close_time, ss_timer;
    scs_volt_t line_volts, bus_volts, uv_set, ov_set, diff_set, ss_uv_set;
    scs_vblk_t vblock_sel;
    int fail_count = 0;
    int cmp_count = 0;
    // ten cycles per timer step keeps the timed cases short
    scs_top #(.TICK_CYCLES(17'h0000A)) dut (.clock(clock), .rst_n(rst_n), .meas_update(meas_update),
        .line_live(line_live), .bus_live(bus_live), .phase_angle(phase_angle), .angle_decreasing(angle_decreasing),
        .slip_freq(slip_freq), .line_volts(line_volts), .bus_volts(bus_volts), .checks_enable(checks_enable),
        .s1_status(s1_status), .s1_user_en(s1_user_en), .s1_angle(s1_angle), .s1_slip_mode(s1_slip_mode),
        .s1_slip(s1_slip), .s1_timer(s1_timer), .s2_status(s2_status), .s2_user_en(s2_user_en),
        .s2_angle(s2_angle), .s2_slip_mode(s2_slip_mode), .s2_comp(s2_comp), .s2_slip(s2_slip),
        .s2_timer(s2_timer), .cb_close_time(cb_close_time), .vblock_sel(vblock_sel), .uv_set(uv_set),
        .ov_set(ov_set), .diff_set(diff_set), .ss_status(ss_status), .ss_user_en(ss_user_en),
        .ss_angle(ss_angle), .ss_uv_block(ss_uv_block), .ss_uv_set(ss_uv_set), .ss_timer(ss_timer),
        .sync_stage_one(sync_stage_one), .sync_stage_two(sync_stage_two), .sync_either(sync_either),
        .system_split(system_split));
    scs_psl_model psl (.clock(clock), .rst_n(rst_n), .req_s1(req_s1), .req_s2(req_s2), .req_ss(req_ss),
        .sync_either(sync_either), .s1_user_en(s1_user_en), .s2_user_en(s2_user_en),
        .ss_user_en(ss_user_en), .close_cmd(close_cmd));
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(string nm, logic e, logic s);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask : chk
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic upd();
        meas_update = 1'b1;
        step(1);
        meas_update = 1'b0;
    endtask : upd
    function automatic logic vb_ok();
        scs_volt_t d;
        d = (line_volts > bus_volts) ? line_volts - bus_volts : bus_volts - line_volts;
        return (!vblock_sel[0] || (line_volts > uv_set && bus_volts > uv_set))
            && (!vblock_sel[1] || (line_volts < ov_set && bus_volts < ov_set))
            && (!vblock_sel[2] || d < diff_set);
    endfunction : vb_ok
    function automatic logic exp_stage(logic two, logic en, scs_ang_t a, scs_slip_e m, scs_slip_t s);
        return checks_enable && en && line_live && bus_live && vb_ok() && phase_angle < a
            && (!(m inside {SCS_SLIP_FREQ, SCS_SLIP_BOTH}) || slip_freq < s) && (!two || angle_decreasing);
    endfunction : exp_stage
    function automatic logic exp_ss();
        return checks_enable && ss_status && req_ss && line_live && bus_live && phase_angle > ss_angle
            && (!ss_uv_block || (line_volts > ss_uv_set && bus_volts > ss_uv_set));
    endfunction : exp_ss
    task automatic check_all();
        logic e1, e2;
        e1 = exp_stage(1'b0, s1_status && req_s1, s1_angle, s1_slip_mode, s1_slip);
        e2 = exp_stage(1'b1, s2_status && req_s2, s2_angle, s2_slip_mode, s2_slip);
        chk("stage_one", e1, sync_stage_one);
        chk("stage_two", e2, sync_stage_two);
        chk("either", e1 || e2, sync_either);
        chk("close", e1 || e2, close_cmd);
        chk("split", exp_ss(), system_split);
    endtask : check_all
    initial
    begin
        repeat (100000) @(posedge clock);
        fail_count++;
        summarize();
    end
    initial
    begin
        {rst_n, meas_update, line_live, bus_live, angle_decreasing, checks_enable, s1_status} = '0;
        {s2_status, s2_comp, ss_status, ss_uv_block, req_s1, req_s2, req_ss} = '0;
        {phase_angle, s1_angle, s2_angle, ss_angle, slip_freq, s1_slip, s2_slip} = '0;
        s1_slip_mode = SCS_SLIP_NONE;
        s2_slip_mode = SCS_SLIP_NONE;
        {s1_timer, s2_timer, cb_close_time, ss_timer, vblock_sel} = '0;
        {line_volts, bus_volts, uv_set, ov_set, diff_set, ss_uv_set} = '0;
        void'($urandom(32'hC05D));
        step(20);
        chk("split_in_reset", 1'b0, system_split);
        rst_n = 1'b1;
        step(2);
        // random sweep, timers zero so every update settles well within the wait
        repeat (250)
        begin
            {checks_enable, s1_status, s2_status, ss_status} = 4'($urandom | $urandom);
            {req_s1, req_s2, req_ss, line_live, bus_live} = 5'($urandom | $urandom);
            {angle_decreasing, ss_uv_block} = 2'($urandom);
            phase_angle = 8'($urandom % 40);
            {s1_angle, s2_angle, ss_angle} = {8'($urandom % 40), 8'($urandom % 40), 8'($urandom % 40)};
            slip_freq = 16'($urandom % 300);
            {s1_slip, s2_slip} = {16'($urandom % 300), 16'($urandom % 300)};
            s1_slip_mode = scs_slip_e'($urandom % 4);
            s2_slip_mode = scs_slip_e'($urandom % 4);
            vblock_sel = 3'($urandom);
            line_volts = 16'(60 + $urandom % 100);
            bus_volts = 16'(int'(line_volts) + $urandom % 30 - 15);
            {uv_set, ov_set, diff_set} = {16'(40 + $urandom % 60), 16'(100 + $urandom % 60), 16'($urandom % 30)};
            ss_uv_set = 16'(40 + $urandom % 60);
            upd();
            step(14);
            check_all();
        end
        // timed slip control: all conditions good, outputs wait for their timers
        {checks_enable, s1_status, s2_status, ss_status, req_s1, req_s2, req_ss} = '1;
        {line_live, bus_live, angle_decreasing, vblock_sel} = {3'b111, 3'b000};
        {phase_angle, s1_angle, s2_angle, slip_freq, s1_slip} = {8'h05, 8'h14, 8'h14, 16'h000A, 16'h0064};
        s1_slip_mode = SCS_SLIP_BOTH;
        s2_slip_mode = SCS_SLIP_TIMER;
        {s1_timer, s2_timer} = {14'h0003, 14'h0008};
        upd();
        step(15);
        chk("s1_timer_early", 1'b0, sync_stage_one);
        chk("s2_timer_early", 1'b0, sync_stage_two);
        step(35);
        chk("s1_timer_done", 1'b1, sync_stage_one);
        chk("s2_timer_mid", 1'b0, sync_stage_two);
        step(50);
        chk("s2_timer_done", 1'b1, sync_stage_two);
        line_live = 1'b0;
        upd();
        step(4);
        chk("s1_dead_line", 1'b0, sync_stage_one);
        line_live = 1'b1;
        upd();
        step(15);
        chk("s1_timer_restart", 1'b0, sync_stage_one);
        slip_freq = 16'h00C8;
        upd();
        step(60);
        chk("s1_both_slip", 1'b0, sync_stage_one);
        // close time 50 ms at 200 mHz advances 3.6 degrees, so 12 passes and 14 fails
        {s2_comp, phase_angle, s2_angle, slip_freq} = {1'b1, 8'h0C, 8'h0A, 16'h00C8};
        {s2_slip, cb_close_time} = {16'h00FA, 14'h0005};
        s2_slip_mode = SCS_SLIP_FREQ;
        upd();
        step(4);
        chk("s2_comp_accept", 1'b1, sync_stage_two);
        phase_angle = 8'h0E;
        upd();
        step(4);
        chk("s2_comp_reject", 1'b0, sync_stage_two);
        s2_comp = 1'b0;
        // split stretch and its undervoltage block
        {phase_angle, ss_angle, ss_uv_block, ss_timer} = {8'h96, 8'h78, 1'b1, 14'h0002};
        {line_volts, bus_volts, ss_uv_set} = {16'h0064, 16'h0064, 16'h0032};
        upd();
        step(3);
        chk("split_set", 1'b1, system_split);
        phase_angle = 8'h1E;
        upd();
        step(5);
        chk("split_held", 1'b1, system_split);
        step(40);
        chk("split_dropped", 1'b0, system_split);
        {phase_angle, line_volts} = {8'h96, 16'h0028};
        upd();
        step(5);
        chk("split_uv_block", 1'b0, system_split);
        summarize();
    end
endmodule : scs_top_tb_top
`default_nettype wire
